// file: bench/hpcfg_host_model.sv
// hpcfg_host_model: behavioural smbus/eeprom loader on the byte register port.
// assumes the bench calls one task at a time; requests launch at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module hpcfg_host_model (
   input  wire logic                  clk,
   input  wire logic [7:0]            rdata,
   input  wire logic                  rvalid,
   output var  hpcfg_pkg::hpcfg_req_t req
);
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(posedge clk) req <= '0;
   endtask : wr
   // strobe is one cycle wide; the answer stands only in the cycle after it
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk) req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk) req <= '0;
      #1;
      d = rdata;
      v = rvalid;
   endtask : rd
endmodule : hpcfg_host_model
`default_nettype wire

// file: bench/tb_hub_port_power_config_regs.sv
// tb_hub_port_power_config_regs: self-checking bench for the config bank.
// assumes hpcfg_pkg compiled first and the host model driving req.
`timescale 1ns/1ps
`default_nettype none
module tb_hub_port_power_config_regs;
   logic                   clk = 1'b0;
   logic                   sys_rst = 1'b1;
   logic [4:0]             ins = 5'h00;
   logic [7:0]             rdata;
   logic                   rvalid;
   hpcfg_pkg::hpcfg_req_t  req;
   hpcfg_pkg::hpcfg_desc_t desc;
   int                     n_mismatch = 0;
   int                     checks = 0;
   always #50 clk = ~clk;
   hpcfg_host_model u_hpcfg_host_model (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
   hpcfg_regs u_hpcfg_regs (.clk(clk), .sys_rst(sys_rst), .req(req),
      .power_source_select(ins[4]), .dynamic_switch_en(ins[3]),
      .local_power_present_pin(ins[2]), .compound_en(ins[1]),
      .use_internal_default(ins[0]), .rdata(rdata), .rvalid(rvalid), .desc(desc));
   task automatic chk(input string n, input logic [21:0] e, input logic [21:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      u_hpcfg_host_model.rd(a, d, v);
      chk($sformatf("rvalid %h", a), 22'h1, {21'h0, v});
      chk($sformatf("rdata %h", a), {14'h0, e}, {14'h0, d});
   endtask : rchk
   task automatic test_reset();
      chk("desc after reset", {2'b00, 2'b11, 2'b11, 16'h0000}, desc);
      for (int a = 9; a <= 14; a++) rchk(8'(a), 8'h00);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_regs();
      // reserved bits set on purpose; the bank must drop them
      u_hpcfg_host_model.wr(8'h09, 8'hfb);
      // disable registers get contiguous ports and clean reserved bits only
      u_hpcfg_host_model.wr(8'h0a, 8'h04);
      u_hpcfg_host_model.wr(8'h0b, 8'h02);
      u_hpcfg_host_model.wr(8'h0c, 8'h32);
      u_hpcfg_host_model.wr(8'h0d, 8'h64);
      u_hpcfg_host_model.wr(8'h0e, 8'h19);
      rchk(8'h09, 8'h02);
      rchk(8'h0a, 8'h04);
      rchk(8'h0b, 8'h02);
      rchk(8'h0c, 8'h32);
      rchk(8'h0d, 8'h64);
      rchk(8'h0e, 8'h19);
      $display("test_regs done");
   endtask : test_regs
   task automatic test_unmapped();
      u_hpcfg_host_model.wr(8'h0f, 8'haa);
      u_hpcfg_host_model.wr(8'h08, 8'h55);
      rchk(8'h0f, 8'h00);
      rchk(8'h08, 8'h00);
      rchk(8'h0e, 8'h19);
      $display("test_unmapped done");
   endtask : test_unmapped
   task automatic test_desc();
      // {select, dynamic, pin, compound, default}
      logic [4:0]  tbl [4] = '{5'b10000, 5'b00111, 5'b01101, 5'b11011};
      logic        s;
      logic [21:0] e;
      foreach (tbl[i]) begin
         @(posedge clk) ins <= tbl[i];
         repeat (2) @(posedge clk);
         #1;
         s = tbl[i][3] ? tbl[i][2] : tbl[i][4];
         e = {s, tbl[i][1], s ? 2'b01 : 2'b10, 2'b10, s ? 8'h32 : 8'h64,
              tbl[i][0] ? 8'h32 : 8'h19};
         chk($sformatf("desc mode %0d", i), e, desc);
         chk("power counts", {6'h0, e[15:0]}, {6'h0, desc[15:0]});
      end
      $display("test_desc done");
   endtask : test_desc
   task automatic test_mid_reset();
      @(posedge clk) begin
         sys_rst <= 1'b1;
         ins     <= 5'b01001;
      end
      repeat (2) @(posedge clk);
      #1;
      chk("desc in reset", 22'h0, desc);
      @(posedge clk) sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("desc after mid reset", {2'b00, 2'b11, 2'b11, 8'h00, 8'h32}, desc);
      rchk(8'h0a, 8'h00);
      $display("test_mid_reset done");
   endtask : test_mid_reset
   task automatic stop_test();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      test_reset();
      test_regs();
      test_unmapped();
      test_desc();
      test_mid_reset();
      stop_test();
   end
   // run needs roughly 70 cycles; allow ample margin
   initial begin
      #(1000 * 100);
      n_mismatch++;
      stop_test();
   end
endmodule : tb_hub_port_power_config_regs
`default_nettype wire

// file: logic/hpcfg_pkg.sv
// hpcfg_pkg: register map, field layout and carrier types for the hub
// port/power configuration bank.
// assumes a byte-wide register port driven by the smbus/eeprom loader.
package hpcfg_pkg;
   localparam int        ADDR_W          = 8;
   localparam int        DATA_W          = 8;
   localparam int        NUM_PORTS       = 2;
   localparam logic [7:0] OFS_FIXED_DEV  = 8'h09;
   localparam logic [7:0] OFS_DIS_SP     = 8'h0a;
   localparam logic [7:0] OFS_DIS_BP     = 8'h0b;
   localparam logic [7:0] OFS_MAXPWR_SP  = 8'h0c;
   localparam logic [7:0] OFS_MAXPWR_BP  = 8'h0d;
   localparam logic [7:0] OFS_HCCUR_SP   = 8'h0e;
   localparam logic [7:0] RST_VAL        = 8'h00;
   // only bits 2:1 exist in the port registers
   localparam logic [7:0] PORT_MASK      = 8'h06;
   localparam int        PORT_LSB        = 1;
   localparam int        MA_PER_UNIT     = 2;
   // internal default: 50 counts = 100 mA
   localparam logic [7:0] DFLT_HCCUR     = 8'h32;

   typedef struct packed {
      logic                 wr_en;
      logic                 rd_en;
      logic [ADDR_W-1:0]    addr;
      logic [DATA_W-1:0]    wdata;
   } hpcfg_req_t;

   typedef struct packed {
      logic                 self_powered;
      logic                 compound;
      logic [NUM_PORTS-1:0] port_avail;
      logic [NUM_PORTS-1:0] port_removable;
      logic [7:0]           max_power;
      logic [7:0]           ctrl_current;
   } hpcfg_desc_t;
endpackage : hpcfg_pkg

// file: logic/hpcfg_pwr_sel.sv
// hpcfg_pwr_sel: picks the active power source and its port-disable set.
// assumes inputs synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module hpcfg_pwr_sel (
   input  wire logic       power_source_select,
   input  wire logic       dynamic_switch_en,
   input  wire logic       local_power_present_pin,
   input  wire logic [7:0] dis_sp,
   input  wire logic [7:0] dis_bp,
   output var  logic       self_powered,
   output var  logic [1:0] port_avail
);
   logic [7:0] dis_sel;
   always_comb begin
      // pin overrides the select bit under dynamic switching
      self_powered = dynamic_switch_en ? local_power_present_pin
                                       : power_source_select; // see (RULE13)
      dis_sel      = self_powered ? dis_sp : dis_bp; // see (RULE3) see (RULE4)
      port_avail   = ~dis_sel[hpcfg_pkg::PORT_LSB +: 2];
   end
endmodule : hpcfg_pwr_sel
`default_nettype wire

// file: logic/hpcfg_regs.sv
// hpcfg_regs: per-port and power configuration registers with a
// descriptor-facing output bundle.
// assumes a byte register port from the smbus/eeprom loader, one clock.
// Overview of operation
// (RULE1) port_fixed_device_flags bit1/bit2 mark port 1/2 non-removable.
// (RULE2) bits 7:3 and 0 of that register always read zero.
// (RULE3) self-powered: set bits in port_disable_self_powered make ports unavailable.
// (RULE4) bus-powered: set bits in port_disable_bus_powered make ports unavailable.
// (RULE5) the configurer disables only contiguous ports and writes zero to reserved bits.
// (RULE6) max_power_self_powered is an 8-bit count of 2 mA units.
// (RULE7) the configurer keeps max_power_self_powered at or below 50 counts.
// (RULE8) max_power_bus_powered is an 8-bit count of 2 mA units.
// (RULE9) controller_current_self_powered counts hub and board only, in 2 mA units.
// (RULE10) all counts scale at 2 mA per unit, 50 meaning 100 mA.
// (RULE11) internal default configuration applies 50 counts as controller current.
// (RULE12) a compound bit selects whether embedded-peripheral accounting applies.
// (RULE13) power_source_select picks self (1) or bus (0) unless dynamic switching follows the pin.
// (RULE14) selected power counts and removable flags feed the upstream descriptors.
`timescale 1ns/1ps
`default_nettype none
module hpcfg_regs (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire hpcfg_pkg::hpcfg_req_t    req,
   input  wire logic                     power_source_select,
   input  wire logic                     dynamic_switch_en,
   input  wire logic                     local_power_present_pin,
   input  wire logic                     compound_en,
   input  wire logic                     use_internal_default,
   output var  logic [7:0]               rdata,
   output var  logic                     rvalid,
   output var  hpcfg_pkg::hpcfg_desc_t   desc
);
   logic [7:0] fixed_r, fixed_nxt;
   logic [7:0] dis_sp_r, dis_sp_nxt;
   logic [7:0] dis_bp_r, dis_bp_nxt;
   logic [7:0] mp_sp_r, mp_sp_nxt;
   logic [7:0] mp_bp_r, mp_bp_nxt;
   logic [7:0] hc_sp_r, hc_sp_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       rvalid_r, rvalid_nxt;
   hpcfg_pkg::hpcfg_desc_t desc_r, desc_nxt;
   logic       self_pw;
   logic [1:0] avail;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   hpcfg_pwr_sel u_sel (
      .power_source_select     (power_source_select),
      .dynamic_switch_en       (dynamic_switch_en),
      .local_power_present_pin (local_power_present_pin),
      .dis_sp                  (dis_sp_r),
      .dis_bp                  (dis_bp_r),
      .self_powered            (self_pw),
      .port_avail              (avail)
   );

   always_comb begin
      fixed_nxt  = fixed_r;
      dis_sp_nxt = dis_sp_r;
      dis_bp_nxt = dis_bp_r;
      mp_sp_nxt  = mp_sp_r;
      mp_bp_nxt  = mp_bp_r;
      hc_sp_nxt  = hc_sp_r;
      if (req.wr_en) begin
         // reserved bits dropped at write so they can never read back
         if (hit(req.addr, hpcfg_pkg::OFS_FIXED_DEV)) begin
            fixed_nxt = req.wdata & hpcfg_pkg::PORT_MASK; // see (RULE1) see (RULE2)
         end
         if (hit(req.addr, hpcfg_pkg::OFS_DIS_SP)) begin
            dis_sp_nxt = req.wdata & hpcfg_pkg::PORT_MASK; // see (RULE3)
         end
         if (hit(req.addr, hpcfg_pkg::OFS_DIS_BP)) begin
            dis_bp_nxt = req.wdata & hpcfg_pkg::PORT_MASK; // see (RULE4)
         end
         if (hit(req.addr, hpcfg_pkg::OFS_MAXPWR_SP)) begin
            mp_sp_nxt = req.wdata; // see (RULE6)
         end
         if (hit(req.addr, hpcfg_pkg::OFS_MAXPWR_BP)) begin
            mp_bp_nxt = req.wdata; // see (RULE8)
         end
         if (hit(req.addr, hpcfg_pkg::OFS_HCCUR_SP)) begin
            hc_sp_nxt = req.wdata; // see (RULE9) see (RULE10)
         end
      end
   end

   always_comb begin
      rvalid_nxt = req.rd_en;
      rdata_nxt  = 8'h00;
      if (req.rd_en) begin
         case (req.addr)
            hpcfg_pkg::OFS_FIXED_DEV: rdata_nxt = fixed_r; // see (RULE2)
            hpcfg_pkg::OFS_DIS_SP:    rdata_nxt = dis_sp_r;
            hpcfg_pkg::OFS_DIS_BP:    rdata_nxt = dis_bp_r;
            hpcfg_pkg::OFS_MAXPWR_SP: rdata_nxt = mp_sp_r;
            hpcfg_pkg::OFS_MAXPWR_BP: rdata_nxt = mp_bp_r;
            hpcfg_pkg::OFS_HCCUR_SP:  rdata_nxt = hc_sp_r;
            default:                  rdata_nxt = 8'h00;
         endcase
      end
   end

   always_comb begin
      desc_nxt                = '0;
      desc_nxt.self_powered   = self_pw; // see (RULE13)
      desc_nxt.compound       = compound_en; // see (RULE12)
      desc_nxt.port_avail     = avail; // see (RULE3) see (RULE4)
      desc_nxt.port_removable = ~fixed_r[hpcfg_pkg::PORT_LSB +: 2]; // see (RULE14)
      desc_nxt.max_power      = self_pw ? mp_sp_r : mp_bp_r; // see (RULE14)
      // controller current is only held for self-powered operation here
      desc_nxt.ctrl_current   = use_internal_default ? hpcfg_pkg::DFLT_HCCUR
                                                     : hc_sp_r; // see (RULE11)
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fixed_r  <= hpcfg_pkg::RST_VAL;
         dis_sp_r <= hpcfg_pkg::RST_VAL;
         dis_bp_r <= hpcfg_pkg::RST_VAL;
         mp_sp_r  <= hpcfg_pkg::RST_VAL;
         mp_bp_r  <= hpcfg_pkg::RST_VAL;
         hc_sp_r  <= hpcfg_pkg::RST_VAL;
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
         desc_r   <= '0;
      end else begin
         fixed_r  <= fixed_nxt;
         dis_sp_r <= dis_sp_nxt;
         dis_bp_r <= dis_bp_nxt;
         mp_sp_r  <= mp_sp_nxt;
         mp_bp_r  <= mp_bp_nxt;
         hc_sp_r  <= hc_sp_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         desc_r   <= desc_nxt;
      end
   end

   assign rdata  = rdata_r;
   assign rvalid = rvalid_r;
   assign desc   = desc_r;

   // attempts start only on a sampled non-reset edge: desc still holds '0 one edge after release
   a_fixed_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE2)
      !sys_rst
      |-> (fixed_r & ~hpcfg_pkg::PORT_MASK) == 8'h00)
      else $error("reserved non-removable bits set");
   a_fixed_write_mask: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE1)
      req.wr_en && req.addr == hpcfg_pkg::OFS_FIXED_DEV
      |=> fixed_r == ($past(req.wdata) & hpcfg_pkg::PORT_MASK))
      else $error("non-removable write not stored");
   a_sp_avail_map: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE3)
      !sys_rst && self_pw
      |=> desc.port_avail == ~$past(dis_sp_r[2:1]))
      else $error("self-powered port disable wrong");
   a_bp_avail_map: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE4)
      !sys_rst && !self_pw
      |=> desc.port_avail == ~$past(dis_bp_r[2:1]))
      else $error("bus-powered port disable wrong");
   a_maxpwr_sel: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE14)
      !sys_rst
      |=> desc.max_power == ($past(self_pw) ? $past(mp_sp_r) : $past(mp_bp_r)))
      else $error("max power selection wrong");
   a_mpsp_store: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE6)
      req.wr_en && req.addr == hpcfg_pkg::OFS_MAXPWR_SP
      |=> mp_sp_r == $past(req.wdata))
      else $error("self max power not stored");
   a_mpbp_store: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE8)
      req.wr_en && req.addr == hpcfg_pkg::OFS_MAXPWR_BP
      |=> mp_bp_r == $past(req.wdata))
      else $error("bus max power not stored");
   a_hcsp_default: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE11)
      !sys_rst && use_internal_default
      |=> desc.ctrl_current == hpcfg_pkg::DFLT_HCCUR)
      else $error("default controller current not 50");
   a_src_select: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE13)
      !sys_rst && dynamic_switch_en
      |=> desc.self_powered == $past(local_power_present_pin))
      else $error("dynamic power source not followed");
   a_src_fixed: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE13)
      !sys_rst && !dynamic_switch_en
      |=> desc.self_powered == $past(power_source_select))
      else $error("selected power source not followed");
   a_hcsp_store: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE9)
      req.wr_en && req.addr == hpcfg_pkg::OFS_HCCUR_SP
      |=> hc_sp_r == $past(req.wdata))
      else $error("controller current not stored");
   a_hcsp_select: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE9)
      !sys_rst && !use_internal_default
      |=> desc.ctrl_current == $past(hc_sp_r))
      else $error("controller current not selected");
   a_read_answer: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE4)
      req.rd_en && req.addr == hpcfg_pkg::OFS_DIS_BP && !req.wr_en
      |=> rvalid && rdata == $past(dis_bp_r))
      else $error("read of bus disable wrong");
   a_dis_sp_mask: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE3)
      req.wr_en && req.addr == hpcfg_pkg::OFS_DIS_SP
      |=> dis_sp_r == ($past(req.wdata) & hpcfg_pkg::PORT_MASK))
      else $error("self-powered disable write not masked");
   a_dis_bp_mask: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE4)
      req.wr_en && req.addr == hpcfg_pkg::OFS_DIS_BP
      |=> dis_bp_r == ($past(req.wdata) & hpcfg_pkg::PORT_MASK))
      else $error("bus-powered disable write not masked");
   a_removable_map: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE1)
      !sys_rst
      |=> desc.port_removable == ~$past(fixed_r[2:1]))
      else $error("removable flags wrong");
   a_compound_pass: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE12)
      !sys_rst
      |=> desc.compound == $past(compound_en))
      else $error("compound flag not passed");
   // a hole in the map answers zero, never stale data from an earlier read
   a_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd_en && (req.addr < hpcfg_pkg::OFS_FIXED_DEV || req.addr > hpcfg_pkg::OFS_HCCUR_SP)
      |=> rvalid && rdata == 8'h00)
      else $error("unmapped read not zero");

   c_sp_mode:  cover property (@(posedge clk) disable iff (sys_rst) self_pw && avail != 2'b11);
   c_bp_mode:  cover property (@(posedge clk) disable iff (sys_rst) !self_pw && avail == 2'b10);
   c_dyn_flip: cover property (@(posedge clk) disable iff (sys_rst) dynamic_switch_en && $rose(self_pw));
   c_undef_rd: cover property (@(posedge clk) disable iff (sys_rst) req.rd_en && req.addr == 8'h0f);
endmodule : hpcfg_regs
`default_nettype wire
